// >>> rtl/ddl_pkg.sv
package ddl_pkg;
   // Serial command word layout.
   localparam int WORD_BITS = 16;
   localparam int BIT_CHAN = 15;
   localparam int BIT_RANGE = 14;
   localparam int BIT_MODE_HI = 13;
   localparam int BIT_MODE_LO = 12;
   localparam int CODE_BITS = 12;
   localparam int CNT_BITS = 5;
   // Sleep mode encodings.
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_1K = 2'h1;
   localparam logic [1:0] MODE_100K = 2'h2;
   localparam logic [1:0] MODE_HIZ = 2'h3;
   // Reset values.
   localparam logic [11:0] CODE_RESET = 12'h000;
   localparam logic RANGE_RESET = 1'b0;
   localparam logic [1:0] MODE_RESET = 2'h0;
   // Wake-up delay, in nanoseconds, at 5 V and 3 V supply.
   localparam int CLOCK_NS = 25;
   localparam int WAKE_5V_NS = 2500;
   localparam int WAKE_3V_NS = 5000;
   localparam int WAKE_5V_CYC = WAKE_5V_NS / CLOCK_NS;
   localparam int WAKE_3V_CYC = WAKE_3V_NS / CLOCK_NS;
   localparam int WAKE_BITS = 8;
   // Host link clock divider: half period in system clocks.
   localparam int HALF_DIV = 4;
   localparam int DIV_BITS = 3;
   // Host register offsets.
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_PINS = 4'h2;
   // Reset value of host pin register: load high, clear high, sleep high.
   localparam logic [2:0] PINS_RESET = 3'h7;
endpackage

// >>> rtl/ddl_link_if.sv
`timescale 1ns/100ps
// Serial link between the master and the converter control.
interface ddl_link_if;
   logic frame_n; // Frame sync, active low chip enable.
   logic sclk; // Shift clock, idles low.
   logic sdata; // Serial data, valid at falling edge.
   logic load_outputs_n; // Load strobe, active low.
   logic clear_all_n; // Asynchronous clear, active low.
   logic sleep_override_n; // Hardware power-down, active low.
   modport master (output frame_n, output sclk, output sdata,
      output load_outputs_n, output clear_all_n,
      output sleep_override_n);
   modport device (input frame_n, input sclk, input sdata,
      input load_outputs_n, input clear_all_n,
      input sleep_override_n);
endinterface

// >>> rtl/ddl_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for a group of pin inputs.
module ddl_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_enable,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] stage1; // First stage, read only by the second.

   // Each bit passes two flip-flops before any logic reads it.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         stage1 <= INIT;
         o_sync <= INIT;
      end else if (i_enable) begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule

// >>> rtl/ddl_device.sv
`timescale 1ns/100ps
module ddl_device #(
   parameter int RESOLUTION = 12 // 12, 10 or 8 bit variant.
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_enable,
   input wire logic i_supply_3v, // Selects the longer wake-up delay.
   ddl_link_if.device link,
   output logic [11:0] o_code_a, // Channel A converter code.
   output logic [11:0] o_code_b, // Channel B converter code.
   output logic o_range_a, // Channel A doubled range.
   output logic o_range_b, // Channel B doubled range.
   output logic [1:0] o_mode_a, // Channel A effective sleep mode.
   output logic [1:0] o_mode_b, // Channel B effective sleep mode.
   output logic o_ready_a, // Channel A output awake and settled.
   output logic o_ready_b, // Channel B output awake and settled.
   output logic o_buffers_on // Shift clock and data buffers powered.
);
   logic [5:0] pins; // Synchronised pins.
   logic frame_n; // Synchronised frame sync.
   logic sclk; // Synchronised shift clock.
   logic sdata; // Synchronised serial data.
   logic load_n; // Synchronised load strobe.
   logic clear_n; // Synchronised clear.
   logic sleep_n; // Synchronised override.
   logic sclk_d; // Shift clock one cycle ago.
   logic frame_d; // Frame sync one cycle ago.
   logic [15:0] shift; // Input shift register.
   logic [4:0] count; // Falling edges taken this frame.
   logic fall; // Falling shift clock edge this cycle.
   logic frame_start; // Falling frame sync this cycle.
   logic done; // Sixteenth edge taken this cycle.
   logic [15:0] word; // Word as it will stand after this edge.
   logic [11:0] code_mask; // Keeps only the variant's code bits.
   logic [11:0] in_reg [2]; // Input registers per channel.
   logic [11:0] dac_reg [2]; // DAC registers per channel.
   logic pending [2]; // Input written since last DAC update.
   logic range_reg [2]; // Latched range per channel.
   logic [1:0] mode_reg [2]; // Latched software mode per channel.
   logic [1:0] eff_mode [2]; // Mode after the override.
   logic [1:0] prev_mode [2]; // Effective mode one cycle ago.
   logic [7:0] wake_cnt [2]; // Cycles left before output is ready.
   logic [7:0] wake_len; // Wake-up length for this supply.

   // Pins come from outside the clock domain.
   // Reset levels: frame, load, clear and override high; clock, data low.
   ddl_sync #(.WIDTH(6), .INIT(6'h27)) u_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_enable(i_enable),
      .i_async({link.frame_n, link.sclk, link.sdata, link.load_outputs_n,
         link.clear_all_n, link.sleep_override_n}),
      .o_sync(pins)
   );
   assign {frame_n, sclk, sdata, load_n, clear_n, sleep_n} = pins;

   // Edge detection on the synchronised shift clock and frame sync.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         sclk_d <= 1'b0;
         frame_d <= 1'b1;
      end else if (i_enable) begin
         sclk_d <= sclk;
         frame_d <= frame_n;
      end
   end
   assign frame_start = frame_d && !frame_n;
   // Edges count only while frame low and buffers powered.
   assign fall = sclk_d && !sclk && !frame_n && o_buffers_on;
   assign done = fall && (count == 5'(ddl_pkg::WORD_BITS - 1));
   assign word = {shift[14:0], sdata};
   // Narrow variants ignore the lowest code bits.
   assign code_mask = 12'hfff << (ddl_pkg::CODE_BITS - RESOLUTION);
   assign wake_len = i_supply_3v ? 8'(ddl_pkg::WAKE_3V_CYC)
      : 8'(ddl_pkg::WAKE_5V_CYC);

   // Shift register and edge counter; frame high clears the counter only.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         shift <= 16'h0000;
         count <= 5'h00;
      end else if (i_enable) begin
         if (frame_n) begin
            count <= 5'h00;
         end else if (fall) begin
            shift <= word;
            count <= count + 5'h01;
         end
      end
   end

   // Buffers power down after a full word, back on at frame fall.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_buffers_on <= 1'b1;
      end else if (i_enable) begin
         if (frame_start) begin
            o_buffers_on <= 1'b1;
         end else if (done) begin
            o_buffers_on <= 1'b0;
         end
      end
   end

   // Per channel registers.
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic hit; // Completed word addresses this channel.
         assign hit = done && (word[ddl_pkg::BIT_CHAN] == 1'(ch));

         // Input register, range and mode; clear zeroes codes only.
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               in_reg[ch] <= ddl_pkg::CODE_RESET;
               range_reg[ch] <= ddl_pkg::RANGE_RESET;
               mode_reg[ch] <= ddl_pkg::MODE_RESET;
            end else if (i_enable && !clear_n) begin
               in_reg[ch] <= ddl_pkg::CODE_RESET;
            end else if (i_enable && hit) begin
               in_reg[ch] <= word[11:0] & code_mask;
               range_reg[ch] <= word[ddl_pkg::BIT_RANGE];
               mode_reg[ch] <= word[ddl_pkg::BIT_MODE_HI:
                  ddl_pkg::BIT_MODE_LO];
            end
         end

         // DAC register follows input while load is low and pending.
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               dac_reg[ch] <= ddl_pkg::CODE_RESET;
               pending[ch] <= 1'b0;
            end else if (i_enable && !clear_n) begin
               dac_reg[ch] <= ddl_pkg::CODE_RESET;
               pending[ch] <= 1'b0;
            end else if (i_enable) begin
               if (hit) begin
                  pending[ch] <= 1'b1;
               end else if (!load_n) begin
                  pending[ch] <= 1'b0;
               end
               if (!load_n && pending[ch]) begin
                  dac_reg[ch] <= in_reg[ch];
               end
            end
         end

         // Override forces high impedance; modes never touch codes.
         assign eff_mode[ch] = sleep_n ? mode_reg[ch]
            : ddl_pkg::MODE_HIZ;

         // Wake-up counter starts when the output leaves sleep.
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               prev_mode[ch] <= ddl_pkg::MODE_RESET;
               wake_cnt[ch] <= 8'h00;
            end else if (i_enable) begin
               prev_mode[ch] <= eff_mode[ch];
               if (eff_mode[ch] != ddl_pkg::MODE_NORMAL) begin
                  wake_cnt[ch] <= 8'h00;
               end else if (prev_mode[ch] != ddl_pkg::MODE_NORMAL) begin
                  wake_cnt[ch] <= wake_len;
               end else if (wake_cnt[ch] != 8'h00) begin
                  wake_cnt[ch] <= wake_cnt[ch] - 8'h01;
               end
            end
         end
      end
   endgenerate

   // Registered outputs.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_code_a <= ddl_pkg::CODE_RESET;
         o_code_b <= ddl_pkg::CODE_RESET;
         o_range_a <= ddl_pkg::RANGE_RESET;
         o_range_b <= ddl_pkg::RANGE_RESET;
         o_mode_a <= ddl_pkg::MODE_RESET;
         o_mode_b <= ddl_pkg::MODE_RESET;
         o_ready_a <= 1'b1;
         o_ready_b <= 1'b1;
      end else if (i_enable) begin
         o_code_a <= dac_reg[0];
         o_code_b <= dac_reg[1];
         o_range_a <= range_reg[0];
         o_range_b <= range_reg[1];
         o_mode_a <= eff_mode[0];
         o_mode_b <= eff_mode[1];
         o_ready_a <= (eff_mode[0] == ddl_pkg::MODE_NORMAL)
            && (prev_mode[0] == ddl_pkg::MODE_NORMAL)
            && (wake_cnt[0] <= 8'h01);
         o_ready_b <= (eff_mode[1] == ddl_pkg::MODE_NORMAL)
            && (prev_mode[1] == ddl_pkg::MODE_NORMAL)
            && (wake_cnt[1] <= 8'h01);
      end
   end
endmodule

// >>> rtl/ddl_master.sv
`timescale 1ns/100ps
// Serial master: sends 16-bit words MSB first and drives control pins.
module ddl_master (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_enable,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_write,
   input wire logic i_read,
   output logic [15:0] o_rdata,
   ddl_link_if.master link
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOW = 3'b010,
      ST_HIGH = 3'b100
   } ddl_state_e;

   ddl_state_e state; // Transfer state.
   logic [15:0] shift; // Word being sent, MSB on the wire.
   logic [4:0] bits; // Bits left to send.
   logic [2:0] div; // Half-period divider.
   logic [2:0] pins; // Load, clear and override pin levels.
   logic busy; // Transfer in progress.
   logic frame_n; // Frame sync output register.
   logic sclk; // Shift clock output register.

   assign busy = (state != ST_IDLE);

   // Shift engine: data set at clock rise, device samples on fall.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= ST_IDLE;
         shift <= 16'h0000;
         bits <= 5'h00;
         div <= 3'h0;
         frame_n <= 1'b1;
         sclk <= 1'b0;
      end else if (i_enable) begin
         unique case (state)
            ST_IDLE: begin
               sclk <= 1'b0;
               if (i_write && i_addr == ddl_pkg::REG_CMD) begin
                  shift <= i_wdata;
                  bits <= 5'(ddl_pkg::WORD_BITS);
                  frame_n <= 1'b0;
                  div <= 3'h0;
                  state <= ST_LOW;
               end else begin
                  frame_n <= 1'b1;
               end
            end
            ST_LOW: begin
               div <= div + 3'h1;
               if (div == 3'(ddl_pkg::HALF_DIV - 1)) begin
                  div <= 3'h0;
                  if (bits == 5'h00) begin
                     frame_n <= 1'b1;
                     state <= ST_IDLE;
                  end else begin
                     sclk <= 1'b1;
                     state <= ST_HIGH;
                     // Next bit moves out on the rise, so it is stable
                     // for the whole high phase and across the fall.
                     if (bits != 5'(ddl_pkg::WORD_BITS)) begin
                        shift <= {shift[14:0], 1'b0};
                     end
                  end
               end
            end
            ST_HIGH: begin
               div <= div + 3'h1;
               if (div == 3'(ddl_pkg::HALF_DIV - 1)) begin
                  div <= 3'h0;
                  sclk <= 1'b0;
                  bits <= bits - 5'h01;
                  state <= ST_LOW;
               end
            end
         endcase
      end
   end

   // Pin register: bit 2 load, bit 1 clear, bit 0 override.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         pins <= ddl_pkg::PINS_RESET;
      end else if (i_enable && i_write && i_addr == ddl_pkg::REG_PINS) begin
         pins <= i_wdata[2:0];
      end
   end

   // Read data stands in the cycle after the read strobe.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_rdata <= 16'h0000;
      end else if (i_enable) begin
         if (i_read && i_addr == ddl_pkg::REG_STATUS) begin
            o_rdata <= {15'h0000, busy};
         end else if (i_read && i_addr == ddl_pkg::REG_PINS) begin
            o_rdata <= {13'h0000, pins};
         end else begin
            o_rdata <= 16'h0000;
         end
      end
   end

   assign link.frame_n = frame_n;
   assign link.sclk = sclk;
   assign link.sdata = shift[15];
   assign link.load_outputs_n = pins[2];
   assign link.clear_all_n = pins[1];
   assign link.sleep_override_n = pins[0];
endmodule

// >>> dv/ddl_link_properties.sv
`timescale 1ns/100ps
// Watches the serial link between the master and device ends.
module ddl_link_properties (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic frame_n,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic load_outputs_n,
   input wire logic clear_all_n,
   input wire logic sleep_override_n
);
   logic sclk_q; // Shift clock one cycle back.
   logic [4:0] falls; // Falling shift clock edges in this frame.
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // Counts falling shift clock edges while the frame is open.
   always_ff @(posedge i_clock) begin
      sclk_q <= sclk;
      if (i_rst || frame_n) begin
         falls <= 5'h0;
      end else if (sclk_q && !sclk) begin
         falls <= falls + 5'h1;
      end
   end
   property p_idle_low; frame_n |-> !sclk; endproperty
   property p_data_held; sclk_q |-> $stable(sdata); endproperty
   property p_lead; $fell(frame_n) |-> !sclk [*4] ##1 sclk; endproperty
   property p_high; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
   property p_whole; $rose(frame_n) |-> falls == 5'h10; endproperty
   property p_max; falls <= 5'h10; endproperty
   property p_close;
      falls == 5'h10 && !frame_n |-> ##[1:8] frame_n;
   endproperty
   property p_pins;
      $fell(i_rst) |-> load_outputs_n && clear_all_n && sleep_override_n;
   endproperty
   a_idle_low: assert property (p_idle_low)
      else $error("shift clock moved outside a frame");
   a_data_held: assert property (p_data_held)
      else $error("data changed while shift clock high");
   a_lead: assert property (p_lead)
      else $error("frame start to first clock spacing wrong");
   a_high: assert property (p_high)
      else $error("shift clock high time wrong");
   a_whole: assert property (p_whole)
      else $error("frame closed without sixteen falls");
   a_max: assert property (p_max)
      else $error("more than sixteen falls in a frame");
   a_close: assert property (p_close)
      else $error("frame left open after last bit");
   a_pins: assert property (p_pins)
      else $error("control pins not high after reset");
   c_frame: cover property ($rose(frame_n) && falls == 5'h10);
   c_load: cover property ($fell(load_outputs_n));
   c_sleep: cover property ($fell(sleep_override_n));
   c_clear: cover property ($fell(clear_all_n));
endmodule

// >>> dv/dual_dac_serial_load_control_tb_top.sv
`timescale 1ns/100ps
// Joins both ends, drives them through the host port and checks the device outputs.
module dual_dac_serial_load_control_tb_top;
   logic i_clock, i_rst, supply_3v, write, read;
   logic [3:0] addr;
   logic [15:0] wdata, rdata;
   logic [11:0] code_a, code_b, code2_a;
   logic range_a, range_b, ready_a, ready_b, buf_on;
   logic [1:0] mode_a, mode_b;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   // Packed views of the device outputs for compact comparison.
   wire [31:0] codes = {8'h0, code_a, code_b};
   wire [31:0] flags = {23'h0, range_a, range_b, mode_a, mode_b,
      ready_a, ready_b, buf_on};
   ddl_link_if link ();
   ddl_link_if link2 ();
   ddl_master ddl_master_inst (.i_clock(i_clock), .i_rst(i_rst),
      .i_enable(1'b1), .i_addr(addr), .i_wdata(wdata), .i_write(write),
      .i_read(read), .o_rdata(rdata), .link(link));
   ddl_device ddl_device_inst (.i_clock(i_clock), .i_rst(i_rst),
      .i_enable(1'b1), .i_supply_3v(supply_3v), .link(link),
      .o_code_a(code_a), .o_code_b(code_b), .o_range_a(range_a),
      .o_range_b(range_b), .o_mode_a(mode_a), .o_mode_b(mode_b),
      .o_ready_a(ready_a), .o_ready_b(ready_b), .o_buffers_on(buf_on));
   // Second device, narrow variant, driven by the bench for fault cases.
   ddl_device #(.RESOLUTION(8)) ddl_device_inst_b (.i_clock(i_clock),
      .i_rst(i_rst), .i_enable(1'b1), .i_supply_3v(supply_3v),
      .link(link2), .o_code_a(code2_a), .o_code_b(), .o_range_a(),
      .o_range_b(), .o_mode_a(), .o_mode_b(), .o_ready_a(),
      .o_ready_b(), .o_buffers_on());
   ddl_link_properties ddl_link_properties_inst (.i_clock(i_clock),
      .i_rst(i_rst), .frame_n(link.frame_n), .sclk(link.sclk),
      .sdata(link.sdata), .load_outputs_n(link.load_outputs_n),
      .clear_all_n(link.clear_all_n),
      .sleep_override_n(link.sleep_override_n));
   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end
   // Cuts a hung run short.
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   task automatic host_wr(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      write <= 1'b1;
      @(posedge i_clock);
      write <= 1'b0;
   endtask
   task automatic host_rd(input logic [3:0] a, output logic [15:0] d);
      addr <= a;
      read <= 1'b1;
      @(posedge i_clock);
      read <= 1'b0;
      @(posedge i_clock);
      d = rdata;
   endtask
   // Sends one word and polls busy, with a bound on the wait.
   task automatic send(input logic [15:0] w);
      logic [15:0] s;
      int n;
      host_wr(ddl_pkg::REG_CMD, w);
      n = 0;
      do begin
         host_rd(ddl_pkg::REG_STATUS, s);
         n++;
      end while (s[0] !== 1'b0 && n < 400);
      chk("busy", 32'h0, {31'h0, s[0]});
      tick(8);
   endtask
   task automatic pins(input logic [2:0] v);
      host_wr(ddl_pkg::REG_PINS, {13'h0, v});
      tick(8);
   endtask
   // Bench frame on the second link: data set at rise, held over fall.
   task automatic bframe(input logic [15:0] w, input int nf, gap);
      link2.frame_n <= 1'b0;
      tick(4);
      for (int i = 0; i < nf; i++) begin
         link2.sdata <= (i < 16) ? w[15 - i] : ~w[0];
         link2.sclk <= 1'b1;
         tick(4);
         link2.sclk <= 1'b0;
         tick((i == 7) ? 4 + gap : 4);
      end
      link2.frame_n <= 1'b1;
      link2.sdata <= ~link2.sdata;
      tick(12);
   endtask
   task automatic t_reset();
      logic [15:0] r;
      host_rd(ddl_pkg::REG_PINS, r);
      chk("pins", {29'h0, ddl_pkg::PINS_RESET}, {16'h0, r});
      chk("codes", 32'h0, codes);
      chk("flags", 32'h7, flags);
      $display("test reset done");
   endtask
   task automatic t_load_low();
      pins(3'b011);
      send(16'h4abc);
      chk("codes", 32'habc000, codes);
      chk("flags", 32'h106, flags);
      send(16'h8123);
      chk("codes", 32'habc123, codes);
      chk("flags", 32'h106, flags);
      $display("test load low done");
   endtask
   task automatic t_hold();
      pins(3'b111);
      send(16'h0fff);
      chk("codes", 32'habc123, codes);
      pins(3'b011);
      chk("codes", 32'hfff123, codes);
      $display("test hold done");
   endtask
   task automatic t_modes();
      for (int m = 1; m < 4; m++) begin
         send({2'b00, m[1:0], 12'h055});
         chk("mode", {29'h0, m[1:0], 1'b0}, {29'h0, mode_a, ready_a});
         chk("codes", 32'h055123, codes);
      end
      send(16'h0055);
      chk("wake", 32'h0, {31'h0, ready_a});
      tick(150);
      chk("wake", 32'h1, {31'h0, ready_a});
      supply_3v <= 1'b1;
      send(16'h3055);
      send(16'h0055);
      tick(150);
      chk("wake3", 32'h0, {31'h0, ready_a});
      tick(100);
      chk("wake3", 32'h1, {31'h0, ready_a});
      $display("test modes done");
   endtask
   task automatic t_pins();
      pins(3'b010);
      chk("override", 32'hf, {28'h0, mode_a, mode_b});
      pins(3'b011);
      chk("override", 32'h0, {28'h0, mode_a, mode_b});
      chk("codes", 32'h055123, codes);
      pins(3'b001);
      pins(3'b011);
      chk("codes", 32'h0, codes);
      $display("test pins done");
   endtask
   task automatic t_faults();
      bframe(16'h0abc, 16, 40);
      chk("code2", 32'hab0, {20'h0, code2_a});
      bframe(16'h0123, 8, 0);
      chk("code2", 32'hab0, {20'h0, code2_a});
      bframe(16'h0f5a, 20, 0);
      chk("code2", 32'hf50, {20'h0, code2_a});
      $display("test faults done");
   endtask
   initial begin
      i_rst = 1'b1;
      supply_3v = 1'b0;
      addr = 4'h0;
      wdata = 16'h0;
      write = 1'b0;
      read = 1'b0;
      link2.frame_n = 1'b1;
      link2.sclk = 1'b0;
      link2.sdata = 1'b0;
      link2.load_outputs_n = 1'b0;
      link2.clear_all_n = 1'b1;
      link2.sleep_override_n = 1'b1;
      tick(5);
      i_rst <= 1'b0;
      tick(3);
      t_reset();
      t_load_low();
      t_hold();
      t_modes();
      t_pins();
      t_faults();
      complete_run();
   end
endmodule
